/* hdl/indicator_pkg.sv */
package indicator_pkg;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_HZ         = 50_000_000;
  localparam int unsigned BASE_TICK_NS   = 62_500_000;
  localparam int unsigned CLK_PERIOD_NS  = 1_000_000_000 / CLK_HZ;
  localparam int unsigned TICK_CYCLES    = BASE_TICK_NS / CLK_PERIOD_NS;
  localparam logic [7:0]  ERR_ON_TICKS   = 8'h04;
  localparam logic [7:0]  ERR_OFF_TICKS  = 8'h04;

  // ----------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------
  localparam logic [31:0] CTRL_INDEX     = 32'h0000_404D;
  localparam logic [31:0] CTRL_ADDR      = CTRL_INDEX << 2;
  localparam logic [31:0] STATUS_ADDR    = 32'h0001_0200;
  localparam logic [15:0] CTRL_RESET     = 16'hC026;
  localparam logic [15:0] CTRL_MASK      = 16'hC33F;
  localparam int          SRC_LSB        = 14;
  localparam int          PAT_LSB        = 8;
  localparam int          CNT_LSB        = 4;
  localparam int          ONT_LSB        = 2;
  localparam int          DUTY_LSB       = 0;
  localparam logic [1:0]  RESP_OKAY      = 2'h0;
  localparam logic [1:0]  RESP_DECERR    = 2'h3;

  typedef enum logic [1:0] {SRC_OFF, SRC_POWER, SRC_CHARGER, SRC_MANUAL} src_e;
  typedef enum logic [1:0] {PAT_OFF, PAT_ON, PAT_PULSE, PAT_BURST} pat_e;
  typedef enum logic [1:0] {PH_ON, PH_OFF, PH_GAP} phase_e;

  typedef struct packed {
    logic [31:0] awaddr;
    logic        awvalid;
    logic [31:0] wdata;
    logic [3:0]  wstrb;
    logic        wvalid;
    logic        bready;
    logic [31:0] araddr;
    logic        arvalid;
    logic        rready;
  } axil_req_s;

  typedef struct packed {
    logic        awready;
    logic        wready;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        arready;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
  } axil_rsp_s;

  typedef struct packed {
    logic [15:0] ctrl;
    logic [21:0] pre;
    phase_e      phase;
    logic [7:0]  cnt;
    logic [2:0]  pulses;
    logic        led;
    logic        aw_held;
    logic [31:0] aw_addr;
    logic        w_held;
    logic [31:0] wdata;
    logic [3:0]  wstrb;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
  } state_s;

  // ----------------------------------------------------------------
  // field decoders
  // ----------------------------------------------------------------
  function automatic logic [7:0] on_ticks(input logic [1:0] code);
    case (code)
      2'h0:    on_ticks = 8'h10;
      2'h1:    on_ticks = 8'h04;
      2'h2:    on_ticks = 8'h02;
      default: on_ticks = 8'h01;
    endcase
  endfunction

  function automatic logic [2:0] off_ratio(input logic [1:0] code);
    case (code)
      2'h0:    off_ratio = 3'h1;
      2'h1:    off_ratio = 3'h2;
      2'h2:    off_ratio = 3'h3;
      default: off_ratio = 3'h7;
    endcase
  endfunction

  function automatic logic [2:0] burst_len(input logic [1:0] code);
    case (code)
      2'h0:    burst_len = 3'h1;
      2'h1:    burst_len = 3'h2;
      2'h2:    burst_len = 3'h4;
      default: burst_len = 3'h7;
    endcase
  endfunction

endpackage

/* hdl/status_indicator_pattern_gen.sv */
`timescale 1ns/1ps
// Behaviour
// - source selector bits 15:14 picks indicator drive
// - auto-program failure also shown on indicator
// - manual pattern bits 9:8 used in manual source
// - burst emits 1, 2, 4 or 7 pulses
// - pulse on time 1 s, 250, 125, 62.5 ms
// - off time is on time times ratio
module status_indicator_pattern_gen #(
  parameter int unsigned TICK_CYCLES = indicator_pkg::TICK_CYCLES
) (
  input  wire logic                     aclk,
  input  wire logic                     aresetn,
  input  wire indicator_pkg::axil_req_s axi_req,
  output indicator_pkg::axil_rsp_s      axi_rsp,
  input  wire logic                     power_state_pattern,
  input  wire logic                     charger_pattern,
  input  wire logic                     autoprog_error,
  output logic                          indicator_led
);
  import indicator_pkg::*;

  state_s      s_q;
  state_s      s_d;
  logic [1:0]  src_sel;
  logic [1:0]  pat_sel;
  logic [7:0]  eff_on;
  logic [7:0]  eff_off;
  logic        pulsing;
  logic        burst;
  logic        tick;
  logic        restart;
  logic        do_write;
  logic [15:0] wr_val;
  logic        manual_led;

  // ----------------------------------------------------------------
  // field views and effective pattern
  // ----------------------------------------------------------------
  assign src_sel = s_q.ctrl[SRC_LSB+1:SRC_LSB];
  assign pat_sel = s_q.ctrl[PAT_LSB+1:PAT_LSB];

  always_comb begin
    if (autoprog_error) begin
      // error blink overrides every source so it cannot be masked by software
      eff_on  = ERR_ON_TICKS;
      eff_off = ERR_OFF_TICKS;
      pulsing = 1'b1;
      burst   = 1'b0;
    end else begin
      eff_on  = on_ticks(s_q.ctrl[ONT_LSB+1:ONT_LSB]);
      eff_off = 8'(eff_on * off_ratio(s_q.ctrl[DUTY_LSB+1:DUTY_LSB]));
      pulsing = (pat_sel == PAT_PULSE) || (pat_sel == PAT_BURST);
      burst   = (pat_sel == PAT_BURST);
    end
  end

  assign tick = (s_q.pre == 22'(TICK_CYCLES - 1));

  // ----------------------------------------------------------------
  // bus write decode
  // ----------------------------------------------------------------
  assign do_write = s_q.aw_held && s_q.w_held && !s_q.bvalid;
  always_comb begin
    wr_val = s_q.ctrl;
    if (s_q.wstrb[0]) begin
      wr_val[7:0] = s_q.wdata[7:0];
    end
    if (s_q.wstrb[1]) begin
      wr_val[15:8] = s_q.wdata[15:8];
    end
    wr_val = wr_val & CTRL_MASK;
  end

  // a control write restarts the pattern so new timing starts clean
  assign restart = do_write && (s_q.aw_addr == CTRL_ADDR);

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    s_d = s_q;

    // timebase and pattern engine
    s_d.pre = tick ? 22'h0 : s_q.pre + 22'h1;
    if (restart || !pulsing) begin
      s_d.pre    = 22'h0;
      s_d.phase  = PH_ON;
      s_d.cnt    = 8'h0;
      s_d.pulses = 3'h0;
    end else if (tick) begin
      s_d.cnt = s_q.cnt + 8'h1;
      case (s_q.phase)
        PH_ON: begin
          if (s_q.cnt >= eff_on - 8'h1) begin
            s_d.cnt    = 8'h0;
            s_d.pulses = s_q.pulses + 3'h1;
            s_d.phase  = PH_OFF;
          end
        end
        PH_OFF: begin
          if (s_q.cnt >= eff_off - 8'h1) begin
            s_d.cnt = 8'h0;
            if (burst && s_q.pulses >= burst_len(s_q.ctrl[CNT_LSB+1:CNT_LSB])) begin
              s_d.phase = PH_GAP;
            end else begin
              s_d.phase = PH_ON;
            end
          end
        end
        default: begin
          if (s_q.cnt >= eff_off - 8'h1) begin
            s_d.cnt    = 8'h0;
            s_d.pulses = 3'h0;
            s_d.phase  = PH_ON;
          end
        end
      endcase
    end

    // indicator drive
    case (pat_sel)
      PAT_OFF: manual_led = 1'b0;
      PAT_ON:  manual_led = 1'b1;
      default: manual_led = (s_q.phase == PH_ON);
    endcase
    if (autoprog_error) begin
      s_d.led = (s_q.phase == PH_ON);
    end else begin
      case (src_sel)
        SRC_OFF:     s_d.led = 1'b0;
        SRC_POWER:   s_d.led = power_state_pattern;
        SRC_CHARGER: s_d.led = charger_pattern;
        default:     s_d.led = manual_led;
      endcase
    end

    // write channels, taken in either order
    if (axi_req.awvalid && !s_q.aw_held && !s_q.bvalid) begin
      s_d.aw_held = 1'b1;
      s_d.aw_addr = axi_req.awaddr;
    end
    if (axi_req.wvalid && !s_q.w_held && !s_q.bvalid) begin
      s_d.w_held = 1'b1;
      s_d.wdata  = axi_req.wdata;
      s_d.wstrb  = axi_req.wstrb;
    end
    if (do_write) begin
      s_d.aw_held = 1'b0;
      s_d.w_held  = 1'b0;
      s_d.bvalid  = 1'b1;
      if (s_q.aw_addr == CTRL_ADDR) begin
        s_d.ctrl  = wr_val;
        s_d.bresp = RESP_OKAY;
      end else if (s_q.aw_addr == STATUS_ADDR) begin
        s_d.bresp = RESP_OKAY;
      end else begin
        s_d.bresp = RESP_DECERR;
      end
    end
    if (s_q.bvalid && axi_req.bready) begin
      s_d.bvalid = 1'b0;
    end

    // read channel
    if (axi_req.arvalid && !s_q.rvalid) begin
      s_d.rvalid = 1'b1;
      s_d.rresp  = RESP_OKAY;
      if (axi_req.araddr == CTRL_ADDR) begin
        s_d.rdata = {16'h0, s_q.ctrl};
      end else if (axi_req.araddr == STATUS_ADDR) begin
        s_d.rdata = {24'h0, autoprog_error, s_q.pulses, s_q.phase, 1'b0, s_q.led};
      end else begin
        s_d.rdata = 32'h0;
        s_d.rresp = RESP_DECERR;
      end
    end else if (s_q.rvalid && axi_req.rready) begin
      s_d.rvalid = 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_q        <= '0;
      s_q.ctrl   <= CTRL_RESET;
      s_q.phase  <= PH_ON;
    end else begin
      s_q <= s_d;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign indicator_led       = s_q.led;
  assign axi_rsp.awready     = !s_q.aw_held && !s_q.bvalid;
  assign axi_rsp.wready      = !s_q.w_held && !s_q.bvalid;
  assign axi_rsp.bvalid      = s_q.bvalid;
  assign axi_rsp.bresp       = s_q.bresp;
  assign axi_rsp.arready     = !s_q.rvalid;
  assign axi_rsp.rvalid      = s_q.rvalid;
  assign axi_rsp.rdata       = s_q.rdata;
  assign axi_rsp.rresp       = s_q.rresp;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  a_src_off_dark: assert property (
    (src_sel == SRC_OFF && !autoprog_error) |=> !indicator_led)
    else $error("indicator lit with source off");

  a_error_blink_on: assert property (
    (autoprog_error && s_q.phase == PH_ON) |=> indicator_led)
    else $error("error blink missing during on phase");

  a_manual_const: assert property (
    (src_sel == SRC_MANUAL && pat_sel == PAT_ON && !autoprog_error) |=> indicator_led)
    else $error("constant pattern not lit");

  a_burst_count: assert property (
    (burst && !autoprog_error)
      |-> s_q.pulses <= burst_len(s_q.ctrl[CNT_LSB+1:CNT_LSB]))
    else $error("burst pulse count exceeded");

  a_on_time_len: assert property (
    (s_q.phase == PH_ON && pulsing && $stable(eff_on)) |-> s_q.cnt < eff_on)
    else $error("on phase too long");

  a_off_time_len: assert property (
    (s_q.phase == PH_OFF && pulsing && $stable(eff_off)) |-> s_q.cnt < eff_off)
    else $error("off phase too long");

  a_gap_after_burst: assert property (
    (s_q.phase == PH_OFF && tick && !restart && s_q.cnt == eff_off - 8'h1 && burst
      && s_q.pulses == burst_len(s_q.ctrl[CNT_LSB+1:CNT_LSB])) |=> s_q.phase == PH_GAP)
    else $error("burst not followed by gap");

  a_gap_dark: assert property (
    (s_q.phase == PH_GAP && burst && src_sel == SRC_MANUAL && !autoprog_error)
      |=> !indicator_led)
    else $error("indicator lit during burst gap");

  a_power_follow: assert property (
    (src_sel == SRC_POWER && !autoprog_error)
      |=> indicator_led == $past(power_state_pattern))
    else $error("indicator not following power state");

  a_charger_follow: assert property (
    (src_sel == SRC_CHARGER && !autoprog_error)
      |=> indicator_led == $past(charger_pattern))
    else $error("indicator not following charger");

  a_manual_off: assert property (
    (src_sel == SRC_MANUAL && pat_sel == PAT_OFF && !autoprog_error) |=> !indicator_led)
    else $error("manual off pattern lit");

  a_error_blink_off: assert property (
    (autoprog_error && s_q.phase != PH_ON) |=> !indicator_led)
    else $error("error blink lit outside on phase");

  a_tick_bound: assert property (
    s_q.pre <= 22'(TICK_CYCLES - 1))
    else $error("timebase prescaler overran");

  a_ctrl_unused_zero: assert property (
    (s_q.ctrl & ~CTRL_MASK) == 16'h0000)
    else $error("unused control bits set");

  a_restart_clean: assert property (
    restart |=> (s_q.phase == PH_ON && s_q.cnt == 8'h00 && s_q.pre == 22'h0))
    else $error("control write did not restart pattern");

  a_on_to_off: assert property (
    (s_q.phase == PH_ON && pulsing && tick && !restart && s_q.cnt == eff_on - 8'h1)
      |=> s_q.phase == PH_OFF)
    else $error("on phase did not end on time");

  a_off_to_on: assert property (
    (s_q.phase == PH_OFF && pulsing && !burst && tick && !restart
      && s_q.cnt == eff_off - 8'h1) |=> s_q.phase == PH_ON)
    else $error("off phase did not end on time");

  a_gap_to_on: assert property (
    (s_q.phase == PH_GAP && pulsing && tick && !restart && s_q.cnt == eff_off - 8'h1)
      |=> (s_q.phase == PH_ON && s_q.pulses == 3'h0))
    else $error("burst gap did not end on time");

  a_phase_holds: assert property (
    (pulsing && !tick && !restart) |=> ($stable(s_q.cnt) && $stable(s_q.phase)))
    else $error("pattern moved between ticks");

  a_write_answer: assert property (
    (s_q.aw_held && s_q.w_held && !s_q.bvalid) |=> axi_rsp.bvalid)
    else $error("write response missing");

  a_read_answer: assert property (
    (axi_req.arvalid && axi_rsp.arready) |=> axi_rsp.rvalid)
    else $error("read response missing");

endmodule

/* dv/led_monitor.sv */
`timescale 1ns/1ps
// ----------------------------------------------------------------
// indicator lamp model: measures lit and dark run lengths
// ----------------------------------------------------------------
module led_monitor (
  input  wire logic aclk,
  input  wire logic indicator_led,
  output int        last_on,
  output int        last_off,
  output int        rises
);
  int   run;
  logic prev;

  initial begin
    run      = 0;
    prev     = 1'b0;
    last_on  = 0;
    last_off = 0;
    rises    = 0;
  end

  // sampled on the falling edge so the bench reads settled counts
  always @(negedge aclk) begin
    if (indicator_led !== prev) begin
      if (prev) last_on = run;
      else last_off = run;
      if (indicator_led === 1'b1) rises++;
      run  = 1;
      prev = indicator_led;
    end else begin
      run++;
    end
  end
endmodule

/* dv/tb.sv */
`timescale 1ns/1ps
`define CHK(n, e, s) begin checks_done++; if ((s) !== (e)) begin failures++; \
  $display("Error %s expected %0h seen %0h", n, e, s); end end
module tb;
  import indicator_pkg::*;
  // ----------------------------------------------------------------
  // signals
  // ----------------------------------------------------------------
  localparam int TK = 8;
  logic       aclk, aresetn, pwr, chg, aerr, led;
  axil_req_s  axi_req;
  axil_rsp_s  axi_rsp;
  int         failures, checks_done, cyc, last_on, last_off, rises;
  logic [31:0] d;
  logic [1:0]  r;
  logic [3:0]  ws;

  status_indicator_pattern_gen #(.TICK_CYCLES(TK)) u_status_indicator_pattern_gen (
    .aclk(aclk), .aresetn(aresetn), .axi_req(axi_req), .axi_rsp(axi_rsp),
    .power_state_pattern(pwr), .charger_pattern(chg), .autoprog_error(aerr),
    .indicator_led(led));
  led_monitor u_led_monitor (.aclk(aclk), .indicator_led(led), .last_on(last_on),
    .last_off(last_off), .rises(rises));

  // ----------------------------------------------------------------
  // bus tasks: each channel held until its own ready
  // ----------------------------------------------------------------
  // bready and rready stay high after the first call, so a second call
  // never drives them twice in one time step
  task automatic wr(input logic [31:0] a, input logic [31:0] v);
    axi_req.awaddr <= a; axi_req.wdata <= v; axi_req.wstrb <= ws;
    axi_req.awvalid <= 1'b1; axi_req.wvalid <= 1'b1; axi_req.bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (axi_rsp.awready === 1'b1) axi_req.awvalid <= 1'b0;
      if (axi_rsp.wready === 1'b1) axi_req.wvalid <= 1'b0;
    end while (axi_rsp.bvalid !== 1'b1);
    r = axi_rsp.bresp;
  endtask

  task automatic rd(input logic [31:0] a);
    axi_req.araddr <= a; axi_req.arvalid <= 1'b1; axi_req.rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (axi_rsp.arready === 1'b1) axi_req.arvalid <= 1'b0;
    end while (axi_rsp.rvalid !== 1'b1);
    d = axi_rsp.rdata; r = axi_rsp.rresp;
  endtask

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_regs();
    rd(STATUS_ADDR);
    `CHK("status reset", 32'h00000000, d)
    rd(CTRL_ADDR);
    `CHK("ctrl reset", 32'h0000C026, d)
    `CHK("led reset", 1'b0, led)
    wr(CTRL_ADDR, 32'h0000FFFF);
    `CHK("ctrl wr resp", RESP_OKAY, r)
    rd(CTRL_ADDR);
    `CHK("ctrl mask", 32'h0000C33F, d)
    ws = 4'h1;
    wr(CTRL_ADDR, 32'h00000000);
    ws = 4'hF;
    rd(CTRL_ADDR);
    `CHK("ctrl low strobe", 32'h0000C300, d)
    wr(32'h0000_0000, 32'h0000FFFF);
    `CHK("unmapped wr resp", RESP_DECERR, r)
    wr(STATUS_ADDR, 32'h0000FFFF);
    `CHK("status wr resp", RESP_OKAY, r)
    rd(CTRL_ADDR);
    `CHK("ctrl kept", 32'h0000C300, d)
    rd(32'h0000_0000);
    `CHK("unmapped resp", RESP_DECERR, r)
  endtask

  task automatic t_source();
    for (int i = 0; i < 8; i++) begin
      pwr <= i[2]; chg <= !i[2];
      wr(CTRL_ADDR, {16'h0, i[1:0], 14'h0});
      repeat (3) @(posedge aclk);
      `CHK("source led", (i[1:0] == 2'h1 && i[2]) || (i[1:0] == 2'h2 && !i[2]), led)
    end
    wr(CTRL_ADDR, 32'h0000C100);
    repeat (3) @(posedge aclk);
    `CHK("manual on", 1'b1, led)
  endtask

  task automatic pulse(input int ont, input int duty, input int on, input int off);
    wr(CTRL_ADDR, 32'h0000C200 | (ont << 2) | duty);
    repeat (2 * (on + off) + 8) @(posedge aclk);
    `CHK("on time", on, last_on)
    `CHK("off time", off, last_off)
  endtask

  task automatic t_burst(input int code, input int n);
    int r0;
    wr(CTRL_ADDR, 32'h0);
    repeat (4) @(posedge aclk);
    r0 = rises;
    wr(CTRL_ADDR, 32'h0000C30C | (code << 4));
    // window ends before the next burst would start
    repeat (n * 2 * TK + TK - 2) @(posedge aclk);
    `CHK("burst pulses", n, rises - r0)
  endtask

  task automatic t_error();
    wr(CTRL_ADDR, 32'h0);
    aerr <= 1'b1;
    repeat (200) @(posedge aclk);
    `CHK("error on", 4 * TK, last_on)
    `CHK("error off", 4 * TK, last_off)
    rd(STATUS_ADDR);
    `CHK("status error bit", 32'h00000080, d & 32'h00000080)
    aerr <= 1'b0;
  endtask

  // ----------------------------------------------------------------
  // run control
  // ----------------------------------------------------------------
  task automatic end_sim();
    $display("checks %0d mismatches %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  initial begin
    aclk = 1'b0;
    forever #10 aclk = ~aclk;
  end

  // whole run needs under 10k cycles; generous ceiling
  always @(posedge aclk) begin
    cyc++;
    if (cyc == 60000) begin
      failures++;
      end_sim();
    end
  end

  initial begin
    failures = 0; checks_done = 0; cyc = 0;
    aresetn = 1'b0; pwr = 1'b0; chg = 1'b0; aerr = 1'b0; axi_req = '0; ws = 4'hF;
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    t_regs();
    t_source();
    pulse(0, 0, 16 * TK, 16 * TK);
    pulse(1, 0, 4 * TK, 4 * TK);
    pulse(2, 0, 2 * TK, 2 * TK);
    pulse(3, 1, TK, 2 * TK);
    pulse(3, 2, TK, 3 * TK);
    pulse(3, 3, TK, 7 * TK);
    t_burst(0, 1);
    t_burst(1, 2);
    t_burst(2, 4);
    t_burst(3, 7);
    t_error();
    end_sim();
  end
endmodule
